// *** rtl/wdc_pkg.sv ***
// package: register map, field positions, reset values and timing for the watchdog block
`default_nettype none
package wdc_pkg;
    // ------------------------------------------------------------
    // register offsets (byte addresses on the plain port)
    // ------------------------------------------------------------
    localparam logic [2:0] OFF_CTRL_ONE    = 3'h0;
    localparam logic [2:0] OFF_CNT_HIGH    = 3'h2;
    localparam logic [2:0] OFF_CNT_LOW     = 3'h3;
    localparam logic [2:0] OFF_TOV_HIGH    = 3'h4;
    localparam logic [2:0] OFF_TOV_LOW     = 3'h5;
    // ------------------------------------------------------------
    // control one field positions
    // ------------------------------------------------------------
    localparam int BIT_ENABLE   = 7;
    localparam int BIT_IRQ      = 6;
    localparam int BIT_UPDATE   = 5;
    localparam int BIT_TST_HI   = 4;
    localparam int BIT_TST_LO   = 3;
    localparam int BIT_DEBUG    = 2;
    localparam int BIT_WAIT     = 1;
    localparam int BIT_STOP     = 0;
    // ------------------------------------------------------------
    // reset values and test field encodings
    // ------------------------------------------------------------
    localparam logic [7:0]  RST_CTRL_ONE = 8'h80;
    localparam logic [15:0] RST_TIMEOUT  = 16'h0004;
    localparam logic [1:0]  TST_OFF      = 2'h0;
    localparam logic [1:0]  TST_USER     = 2'h1;
    localparam logic [1:0]  TST_LOW      = 2'h2;
    localparam logic [1:0]  TST_HIGH     = 2'h3;
    // ------------------------------------------------------------
    // key sequences and timing in bus clocks
    // ------------------------------------------------------------
    localparam logic [15:0] KEY_UNLOCK_A  = 16'h20C5;
    localparam logic [15:0] KEY_UNLOCK_B  = 16'h28D9;
    localparam logic [15:0] KEY_REFRESH_A = 16'h02A6;
    localparam logic [15:0] KEY_REFRESH_B = 16'h80B4;
    localparam int          SEQ_GAP_CYC   = 16;
    localparam int          UNLOCK_CYC    = 128;
    localparam int          RST_DELAY_CYC = 128;
endpackage
`default_nettype wire

// *** rtl/wdc_countdown.sv ***
// down counter that marks the end of a fixed number of cycles
`timescale 1ns/100ps
`default_nettype none
module wdc_countdown #(
    parameter int COUNT = 128
) (
    input  wire logic i_ref_clk,
    input  wire logic i_rst,
    input  wire logic i_start,
    input  wire logic i_abort,
    output logic      o_busy,
    output logic      o_done
);
    localparam int W = $clog2(COUNT + 1);
    logic [W-1:0] cnt_ff;

    if (COUNT < 1)
    begin : g_count_check
        $error("countdown needs COUNT of at least one");
    end

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            cnt_ff <= '0;
        else if (i_abort)
            cnt_ff <= '0;
        else if (i_start)
            cnt_ff <= W'(COUNT);
        else if (cnt_ff != '0)
            cnt_ff <= cnt_ff - W'(1);
    end

    assign o_busy = (cnt_ff != '0);
    assign o_done = (cnt_ff == W'(1));
endmodule
`default_nettype wire

// *** rtl/wdc_watchdog.sv ***
// watchdog core: control one register, counter, timeout compare, key sequences, reset request
// Contract
// - counter runs only while the enable bit 7 is set
// - enable bit takes only the first write after reset, unless unlocked
// - interrupt bit 6 set: any reset event raises an interrupt first
// - with interrupt set, reset follows 128 clocks after the vector fetch
// - interrupt bit clear: no interrupt, reset at once on the event
// - update bit 5 set: configuration writes accepted for 128 clocks after unlock
// - update bit clear: no configuration change after the first one
// - test field cleared only by power-on reset; write-once (the code also takes a new value while unlocked)
// - test field 10 compares low counter byte with low timeout byte
// - test field 11 compares high counter byte with high timeout byte
// - test field 00 or 01 uses the full 16-bit compare
// - test mode lets software exercise each counter bit quickly
// - in debug mode the counter runs only if the debug bit is set
// - in wait mode the counter runs only if the wait bit is set
// - in stop mode the counter runs only if the stop bit is set
// - unlock is 0x20C5 then 0x28D9 to the counter within 16 clocks
// - refresh is 0x02A6 then 0x80B4 within 16 clocks; clears the counter
// - counter is compared with timeout; a match forces a reset
// - any other counter write is illegal and forces a reset
//
// The implementer's own choice: strobed register access.
`timescale 1ns/100ps
`default_nettype none
module wdc_watchdog (
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst,
    input  wire logic       i_por,
    input  wire logic [2:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    input  wire logic       i_debug_mode,
    input  wire logic       i_wait_mode,
    input  wire logic       i_stop_mode,
    input  wire logic       i_vector_fetch,
    output logic            o_irq,
    output logic            o_wdog_reset
);
    // ------------------------------------------------------------
    // synchronise chip mode levels and the vector fetch pin
    // ------------------------------------------------------------
    logic [3:0] sync1_ff;
    logic [3:0] sync2_ff;
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            sync1_ff <= 4'h0;
            sync2_ff <= 4'h0;
        end
        else
        begin
            sync1_ff <= {i_vector_fetch, i_stop_mode, i_wait_mode, i_debug_mode};
            sync2_ff <= sync1_ff;
        end
    end
    wire logic dbg_s   = sync2_ff[0];
    wire logic wait_s  = sync2_ff[1];
    wire logic stop_s  = sync2_ff[2];
    wire logic fetch_s = sync2_ff[3];

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0]  ctrl_ff;        // test field bits held in tst_ff
    logic [1:0]  tst_ff;
    logic        tst_done_ff;
    logic        cfg_done_ff;
    logic [15:0] cnt_ff;
    logic [15:0] tov_ff;
    logic [7:0]  tov_hold_ff;    // high byte staged until low byte completes pair
    logic [7:0]  key_hi_ff;
    logic        key_hi_vld_ff;
    logic [15:0] key_first_ff;
    logic        key_first_vld_ff;
    logic [4:0]  key_age_ff;
    logic        irq_ff;
    logic        rst_req_ff;
    logic [7:0]  rdata_ff;

    wire logic unlock_open;
    wire logic unlock_done;
    wire logic irq_delay_busy;
    wire logic irq_delay_done;

    // ------------------------------------------------------------
    // counter key sequences: two byte writes form one 16-bit word
    // ------------------------------------------------------------
    wire logic cnt_wr_hi = i_wr && (i_addr == wdc_pkg::OFF_CNT_HIGH);
    wire logic cnt_wr_lo = i_wr && (i_addr == wdc_pkg::OFF_CNT_LOW);
    wire logic [15:0] key_word = {key_hi_ff, i_wdata};
    wire logic word_done = cnt_wr_lo && key_hi_vld_ff;
    wire logic in_gap = key_first_vld_ff && (key_age_ff < 5'(wdc_pkg::SEQ_GAP_CYC));

    logic nxt_unlock_hit;
    logic nxt_refresh_hit;
    logic nxt_first_ok;
    logic illegal_wr;
    always_comb
    begin
        nxt_unlock_hit  = 1'b0;
        nxt_refresh_hit = 1'b0;
        nxt_first_ok    = 1'b0;
        illegal_wr      = 1'b0;
        if (word_done)
        begin
            if (in_gap && key_first_ff == wdc_pkg::KEY_UNLOCK_A
                && key_word == wdc_pkg::KEY_UNLOCK_B)
                nxt_unlock_hit = 1'b1;
            else if (in_gap && key_first_ff == wdc_pkg::KEY_REFRESH_A
                     && key_word == wdc_pkg::KEY_REFRESH_B)
                nxt_refresh_hit = 1'b1;
            else if (key_word == wdc_pkg::KEY_UNLOCK_A
                     || key_word == wdc_pkg::KEY_REFRESH_A)
                nxt_first_ok = 1'b1;
            else
                illegal_wr = 1'b1;
        end
        else if (cnt_wr_lo)
            illegal_wr = 1'b1;
        // a sequence left unfinished past its gap is also an illegal access
        if (key_first_vld_ff && !in_gap && !word_done)
            illegal_wr = 1'b1;
    end

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            key_hi_ff        <= 8'h00;
            key_hi_vld_ff    <= 1'b0;
            key_first_ff     <= 16'h0000;
            key_first_vld_ff <= 1'b0;
            key_age_ff       <= 5'h00;
        end
        else
        begin
            if (cnt_wr_hi)
            begin
                key_hi_ff     <= i_wdata;
                key_hi_vld_ff <= 1'b1;
            end
            else if (cnt_wr_lo)
                key_hi_vld_ff <= 1'b0;
            if (nxt_first_ok)
            begin
                key_first_ff     <= key_word;
                key_first_vld_ff <= 1'b1;
                key_age_ff       <= 5'h00;
            end
            else if (word_done || (key_first_vld_ff && !in_gap))
                key_first_vld_ff <= 1'b0;
            else if (key_first_vld_ff)
                key_age_ff <= key_age_ff + 5'h01;
        end
    end

    // ------------------------------------------------------------
    // unlock window of 128 clocks
    // ------------------------------------------------------------
    wdc_countdown #(
        .COUNT (wdc_pkg::UNLOCK_CYC)
    ) u_unlock (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_start   (nxt_unlock_hit && ctrl_ff[wdc_pkg::BIT_UPDATE]),
        .i_abort   (1'b0),
        .o_busy    (unlock_open),
        .o_done    (unlock_done)
    );

    // a write to configuration is taken once, or again while unlocked
    wire logic cfg_ok = !cfg_done_ff || unlock_open;
    wire logic ctrl_wr = i_wr && (i_addr == wdc_pkg::OFF_CTRL_ONE);
    wire logic tov_wr_hi = i_wr && (i_addr == wdc_pkg::OFF_TOV_HIGH);
    wire logic tov_wr_lo = i_wr && (i_addr == wdc_pkg::OFF_TOV_LOW);

    // ------------------------------------------------------------
    // control one and timeout registers
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ctrl_ff     <= wdc_pkg::RST_CTRL_ONE;
            cfg_done_ff <= 1'b0;
            tov_ff      <= wdc_pkg::RST_TIMEOUT;
            tov_hold_ff <= 8'h00;
        end
        else
        begin
            if (ctrl_wr && cfg_ok)
            begin
                ctrl_ff     <= i_wdata;
                cfg_done_ff <= 1'b1;
            end
            if (tov_wr_hi && cfg_ok)
                tov_hold_ff <= i_wdata;
            if (tov_wr_lo && cfg_ok)
            begin
                tov_ff      <= {tov_hold_ff, i_wdata};
                cfg_done_ff <= 1'b1;
            end
            if (unlock_done)
                cfg_done_ff <= 1'b1;
        end
    end

    // test field survives every reset but power-on
    always_ff @(posedge i_ref_clk or posedge i_por)
    begin
        if (i_por)
        begin
            tst_ff      <= wdc_pkg::TST_OFF;
            tst_done_ff <= 1'b0;
        end
        else if (ctrl_wr && (!tst_done_ff || unlock_open))
        begin
            tst_ff      <= i_wdata[wdc_pkg::BIT_TST_HI:wdc_pkg::BIT_TST_LO];
            tst_done_ff <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // counter, compare and reset request
    // ------------------------------------------------------------
    wire logic run = ctrl_ff[wdc_pkg::BIT_ENABLE]
        && (!dbg_s  || ctrl_ff[wdc_pkg::BIT_DEBUG])
        && (!wait_s || ctrl_ff[wdc_pkg::BIT_WAIT])
        && (!stop_s || ctrl_ff[wdc_pkg::BIT_STOP]);

    logic hit;
    always_comb
    begin
        case (tst_ff)
            wdc_pkg::TST_LOW:  hit = (cnt_ff[7:0] == tov_ff[7:0]);
            wdc_pkg::TST_HIGH: hit = (cnt_ff[15:8] == tov_ff[15:8]);
            default:           hit = (cnt_ff == tov_ff);
        endcase
    end
    wire logic timeout = run && hit;
    wire logic trigger = (timeout || illegal_wr) && !irq_ff && !rst_req_ff;

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            cnt_ff <= 16'h0000;
        else if (nxt_refresh_hit)
            cnt_ff <= 16'h0000;
        else if (run && !hit)
            cnt_ff <= cnt_ff + 16'h0001;
    end

    wdc_countdown #(
        .COUNT (wdc_pkg::RST_DELAY_CYC)
    ) u_delay (
        .i_ref_clk (i_ref_clk),
        .i_rst     (i_rst),
        .i_start   (irq_ff && fetch_s && !irq_delay_busy),
        .i_abort   (1'b0),
        .o_busy    (irq_delay_busy),
        .o_done    (irq_delay_done)
    );

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            irq_ff     <= 1'b0;
            rst_req_ff <= 1'b0;
        end
        else
        begin
            if (trigger && ctrl_ff[wdc_pkg::BIT_IRQ])
                irq_ff <= 1'b1;
            if (trigger && !ctrl_ff[wdc_pkg::BIT_IRQ])
                rst_req_ff <= 1'b1;
            if (irq_delay_done)
                rst_req_ff <= 1'b1;
        end
    end
    assign o_irq        = irq_ff;
    assign o_wdog_reset = rst_req_ff;

    // ------------------------------------------------------------
    // read port, data one cycle after the strobe
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            rdata_ff <= 8'h00;
        else if (i_rd)
        begin
            case (i_addr)
                wdc_pkg::OFF_CTRL_ONE: rdata_ff <= {ctrl_ff[7:5], tst_ff, ctrl_ff[2:0]};
                wdc_pkg::OFF_CNT_HIGH: rdata_ff <= cnt_ff[15:8];
                wdc_pkg::OFF_CNT_LOW:  rdata_ff <= cnt_ff[7:0];
                wdc_pkg::OFF_TOV_HIGH: rdata_ff <= tov_ff[15:8];
                wdc_pkg::OFF_TOV_LOW:  rdata_ff <= tov_ff[7:0];
                default:               rdata_ff <= 8'h00;
            endcase
        end
        else
            rdata_ff <= 8'h00;
    end
    assign o_rdata = rdata_ff;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_stopped_when_off;
        @(posedge i_ref_clk) disable iff (i_rst)
        !ctrl_ff[wdc_pkg::BIT_ENABLE] && !nxt_refresh_hit |=> $stable(cnt_ff);
    endproperty
    a_stopped_when_off: assert property (p_stopped_when_off)
        else $error("counter moved while disabled");

    property p_locked_ctrl;
        @(posedge i_ref_clk) disable iff (i_rst)
        ctrl_wr && cfg_done_ff && !unlock_open |=> $stable(ctrl_ff);
    endproperty
    a_locked_ctrl: assert property (p_locked_ctrl)
        else $error("locked control register changed");

    property p_irq_first;
        @(posedge i_ref_clk) disable iff (i_rst)
        trigger && ctrl_ff[wdc_pkg::BIT_IRQ] |=> o_irq && !o_wdog_reset;
    endproperty
    a_irq_first: assert property (p_irq_first)
        else $error("interrupt not raised before reset");

    property p_delay_128;
        @(posedge i_ref_clk) disable iff (i_rst)
        irq_ff && fetch_s && !irq_delay_busy && !rst_req_ff
            |=> !o_wdog_reset [*8] ##121 o_wdog_reset;
    endproperty
    a_delay_128: assert property (p_delay_128)
        else $error("delayed reset not at 128 clocks");

    property p_direct_reset;
        @(posedge i_ref_clk) disable iff (i_rst)
        trigger && !ctrl_ff[wdc_pkg::BIT_IRQ] |=> o_wdog_reset && !o_irq;
    endproperty
    a_direct_reset: assert property (p_direct_reset)
        else $error("reset not immediate without interrupt");

    property p_refresh_clears;
        @(posedge i_ref_clk) disable iff (i_rst)
        nxt_refresh_hit |=> cnt_ff == 16'h0000;
    endproperty
    a_refresh_clears: assert property (p_refresh_clears)
        else $error("refresh did not clear counter");

    property p_illegal_resets;
        @(posedge i_ref_clk) disable iff (i_rst)
        illegal_wr && !irq_ff && !rst_req_ff |=> o_irq || o_wdog_reset;
    endproperty
    a_illegal_resets: assert property (p_illegal_resets)
        else $error("illegal counter write ignored");

    property p_low_byte_test;
        @(posedge i_ref_clk) disable iff (i_rst)
        run && tst_ff == wdc_pkg::TST_LOW && cnt_ff[7:0] == tov_ff[7:0]
            && !irq_ff && !rst_req_ff |=> o_irq || o_wdog_reset;
    endproperty
    a_low_byte_test: assert property (p_low_byte_test)
        else $error("low byte test timeout missed");

    c_unlock: cover property (@(posedge i_ref_clk) disable iff (i_rst) nxt_unlock_hit);
    c_refresh: cover property (@(posedge i_ref_clk) disable iff (i_rst) nxt_refresh_hit);
    c_delayed: cover property (@(posedge i_ref_clk) disable iff (i_rst) irq_delay_done);
endmodule
`default_nettype wire

// *** test/wdc_watchdog_tb.sv ***
// self-checking testbench for the watchdog core, driven through its plain register port
`timescale 1ns/100ps
`default_nettype none
module wdc_watchdog_tb;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic       ref_clk = 1'b0;
    logic       rst     = 1'b1;
    logic       por     = 1'b1;
    logic [2:0] addr    = 3'h0;
    logic [7:0] wdata   = 8'h00;
    logic       wr      = 1'b0;
    logic       rd      = 1'b0;
    logic [7:0] rdata;
    logic [2:0] modes   = 3'h0;
    logic       vfetch  = 1'b0;
    logic       irq;
    logic       wdog_rst;
    int         error_cnt = 0;
    int         checked   = 0;
    int         cyc       = 0;
    logic [7:0] d;
    int         n;

    always #2.5 ref_clk = ~ref_clk;

    wdc_watchdog wdc_watchdog_i (
        .i_ref_clk      (ref_clk),
        .i_rst          (rst),
        .i_por          (por),
        .i_addr         (addr),
        .i_wdata        (wdata),
        .i_wr           (wr),
        .i_rd           (rd),
        .o_rdata        (rdata),
        .i_debug_mode   (modes[2]),
        .i_wait_mode    (modes[1]),
        .i_stop_mode    (modes[0]),
        .i_vector_fetch (vfetch),
        .o_irq          (irq),
        .o_wdog_reset   (wdog_rst)
    );

    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic chk(input bit ok, input string msg);
        checked++;
        if (!ok)
        begin
            error_cnt++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask

    task automatic wr8(input logic [2:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= v;
        @(posedge ref_clk);
        wr    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd8(input logic [2:0] a, output logic [7:0] v);
        @(posedge ref_clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        rd   <= 1'b0;
        #1 v = rdata;
    endtask

    // key words go high byte first; the low byte completes the word
    task automatic key(input logic [15:0] w);
        wr8(wdc_pkg::OFF_CNT_HIGH, w[15:8]);
        wr8(wdc_pkg::OFF_CNT_LOW, w[7:0]);
    endtask

    task automatic do_reset(input logic with_por);
        @(posedge ref_clk);
        rst <= 1'b1;
        por <= with_por;
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        por <= 1'b0;
    endtask

    // first write keeps the counter off and allows updates, then unlock and reconfigure
    task automatic setup(input logic [7:0] ctl, input logic [15:0] tov);
        wr8(wdc_pkg::OFF_CTRL_ONE, 8'h20);
        key(wdc_pkg::KEY_UNLOCK_A);
        key(wdc_pkg::KEY_UNLOCK_B);
        wr8(wdc_pkg::OFF_TOV_HIGH, tov[15:8]);
        wr8(wdc_pkg::OFF_TOV_LOW, tov[7:0]);
        wr8(wdc_pkg::OFF_CTRL_ONE, ctl);
    endtask

    task automatic wait_rst(input int lim, output int cnt);
        cnt = 0;
        while (wdog_rst !== 1'b1 && cnt < lim)
        begin
            @(posedge ref_clk);
            #1 cnt++;
        end
    endtask

    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // hang guard, far above the few thousand cycles the tests need
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            error_cnt++;
            close_out();
        end
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial
    begin
        do_reset(1'b1);
        rd8(wdc_pkg::OFF_CTRL_ONE, d);
        chk(d === wdc_pkg::RST_CTRL_ONE, "control reset value");
        wait_rst(30, n);
        chk(wdog_rst === 1'b1, "default timeout did not reset");
        chk(irq === 1'b0, "interrupt without interrupt bit");
        $display("test reset_defaults done");

        do_reset(1'b1);
        wr8(wdc_pkg::OFF_CTRL_ONE, 8'h00);
        rd8(wdc_pkg::OFF_CNT_LOW, d);
        repeat (20) @(posedge ref_clk);
        rd8(wdc_pkg::OFF_CNT_LOW, n[7:0]);
        chk(d === n[7:0], "counter moved while disabled");
        chk(wdog_rst === 1'b0, "reset while disabled");
        wr8(wdc_pkg::OFF_CTRL_ONE, 8'h86);
        rd8(wdc_pkg::OFF_CTRL_ONE, d);
        chk(d === 8'h00, "second control write accepted");
        rd8(3'h7, d);
        chk(d === 8'h00, "unmapped read not zero");
        $display("test write_once done");

        do_reset(1'b1);
        setup(8'hA0, 16'h0100);
        rd8(wdc_pkg::OFF_CTRL_ONE, d);
        chk(d === 8'hA0, "unlocked reconfiguration refused");
        repeat (100) @(posedge ref_clk);
        key(wdc_pkg::KEY_REFRESH_A);
        key(wdc_pkg::KEY_REFRESH_B);
        rd8(wdc_pkg::OFF_CNT_HIGH, d);
        chk(d === 8'h00, "refresh left high byte");
        rd8(wdc_pkg::OFF_CNT_LOW, d);
        chk((d < 8'h20) === 1'b1, "refresh left low byte");
        repeat (40) @(posedge ref_clk);
        wr8(wdc_pkg::OFF_CTRL_ONE, 8'h80);
        rd8(wdc_pkg::OFF_CTRL_ONE, d);
        chk(d === 8'hA0, "write taken after unlock window");
        chk(wdog_rst === 1'b0, "refresh sequence reset the chip");
        wait_rst(300, n);
        chk(wdog_rst === 1'b1, "16-bit timeout missed");
        $display("test unlock_refresh done");

        do_reset(1'b1);
        setup(8'hE0, 16'hFFFF);
        wr8(wdc_pkg::OFF_CNT_LOW, 8'h00);
        repeat (6) @(posedge ref_clk);
        chk(irq === 1'b1, "no interrupt on illegal write");
        repeat (50) @(posedge ref_clk);
        chk(wdog_rst === 1'b0, "reset before vector fetch");
        @(posedge ref_clk);
        vfetch <= 1'b1;
        @(posedge ref_clk);
        vfetch <= 1'b0;
        wait_rst(200, n);
        chk(n >= 124 && n <= 136, "reset delay after vector fetch");
        $display("test irq_delay done");

        do_reset(1'b1);
        setup(8'h90, 16'h0305);
        wait_rst(40, n);
        chk(wdog_rst === 1'b1, "low byte test compare");
        $display("test fast_low done");

        do_reset(1'b1);
        setup(8'h98, 16'h0280);
        wait_rst(560, n);
        chk(n >= 490 && n <= 530, "high byte test compare");
        do_reset(1'b0);
        rd8(wdc_pkg::OFF_CTRL_ONE, d);
        chk(d === 8'h98, "test field lost on plain reset");
        do_reset(1'b1);
        rd8(wdc_pkg::OFF_CTRL_ONE, d);
        chk(d === 8'h80, "test field kept on power-on");
        $display("test fast_high done");

        do_reset(1'b1);
        setup(8'h88, 16'h0105);
        repeat (200) @(posedge ref_clk);
        chk(wdog_rst === 1'b0, "user mode used byte compare");
        wait_rst(100, n);
        chk(wdog_rst === 1'b1, "user mode full compare");
        $display("test user_mode done");

        // bit 2 debug, bit 1 wait, bit 0 stop: each halts the counter unless allowed
        for (int b = 2; b >= 0; b--)
        begin
            do_reset(1'b1);
            modes <= 3'h1 << b;
            setup(8'h80, 16'h0040);
            repeat (150) @(posedge ref_clk);
            chk(wdog_rst === 1'b0, "counter ran in low power mode");
            do_reset(1'b1);
            setup(8'h80 | (8'h01 << b), 16'h0040);
            wait_rst(100, n);
            chk(wdog_rst === 1'b1, "counter halted though allowed");
            modes <= 3'h0;
        end
        $display("test mode_enables done");
        close_out();
    end
endmodule
`default_nettype wire
